// file: clock_security_reset_flags_test.sv
// Self-checking bench for cssr_top with oscillator model and reset pin.
// Assumes the bound checker; the reset pin has a pull-up on the board.
`timescale 1ns/1ps

module clock_security_reset_flags_test;
	reg        mclk;
	reg        rst_n;
	reg [15:0] reg_addr;
	reg [7:0]  reg_wdata;
	reg        reg_wr;
	reg        reg_rd;
	reg        sup_opt;
	reg        lvd_req;
	reg        wdg_pulse;
	reg [3:0]  modes;
	reg        ext_low;
	reg [1:0]  osc_mode;
	reg [7:0]  d;
	integer    n_errors;
	integer    total_checks;
	wire [7:0] reg_rdata;
	wire [1:0] cause;
	wire       main_osc, bkp_osc, bkp_en, safe_sel, filt, pin_out, pin_oe;
	wire       cpu_reset, irq_req, wake_req, sys_clk;
	// Open-drain reset pin with pull-up
	wire       pin = (ext_low || (pin_oe && !pin_out)) ? 1'b0 : 1'b1;

	cssr_top cssr_top_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.supervisor_option(sup_opt), .low_voltage_detector_option(1'b1),
		.main_osc_in(main_osc), .backup_osc_in(bkp_osc), .main_osc_enable(),
		.backup_osc_enable(bkp_en), .sys_clk_out(sys_clk), .safe_clock_sel(safe_sel),
		.filter_active(filt), .reset_pin_in(pin), .reset_pin_out(pin_out),
		.reset_pin_oe(pin_oe), .lvd_reset_req(lvd_req), .wdg_reset_pulse(wdg_pulse),
		.cpu_reset(cpu_reset), .reset_cause(cause), .cpu_irq_mask(modes[3]),
		.wait_mode(modes[2]), .halt_mode(modes[1]), .active_halt_mode(modes[0]),
		.irq_req(irq_req), .wake_req(wake_req));
	cssr_osc_model cssr_osc_model_i (.osc_mode(osc_mode), .backup_osc_enable(bkp_en),
		.main_osc_in(main_osc), .backup_osc_in(bkp_osc));

	// 50 MHz clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// ********************************
	// Helpers
	// ********************************
	task check(input [7:0] seen, input [7:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task end_sim;
		begin
			$display("checks %0d errors %0d", total_checks, n_errors);
			if (n_errors == 0 && total_checks > 0) begin
				$display("Finished cleanly");
			end else begin
				$display("Finished with errors");
			end
			$finish;
		end
	endtask
	// Picks safe_sel (0), filt (1), cpu_reset (2) or sys_clk (3)
	function sel_sig(input integer sel);
		begin
			sel_sig = (sel == 0) ? safe_sel : (sel == 1) ? filt : (sel == 2) ? cpu_reset : sys_clk;
		end
	endfunction
	// Waits for the picked signal to reach val
	task wait_for(input integer sel, input val, input integer lim);
		integer n;
		begin
			n = 0;
			@(posedge mclk);
			#1;
			while (sel_sig(sel) !== val && n < lim) begin
				@(posedge mclk);
				#1;
				n = n + 1;
			end
			if (sel_sig(sel) !== val) begin
				n_errors = n_errors + 1;
				end_sim;
			end
		end
	endtask
	task wr(input [15:0] a, input [7:0] v);
		begin
			@(posedge mclk);
			reg_addr <= a;
			reg_wdata <= v;
			reg_wr <= 1'b1;
			@(posedge mclk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [15:0] a);
		begin
			@(posedge mclk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge mclk);
			reg_rd <= 1'b0;
			#1 d = reg_rdata;
		end
	endtask
	task set_modes(input [3:0] m);
		begin
			@(posedge mclk);
			modes <= m;
			@(posedge mclk);
			#1;
		end
	endtask
	task do_reset(input opt);
		begin
			@(posedge mclk);
			rst_n <= 1'b0;
			sup_opt <= opt;
			repeat (5) @(posedge mclk);
			rst_n <= 1'b1;
		end
	endtask
	task pulse_wdg;
		begin
			@(posedge mclk);
			wdg_pulse <= 1'b1;
			@(posedge mclk);
			wdg_pulse <= 1'b0;
			wait_for(2, 1'b0, 6000);
		end
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task t_regs;
		begin
			rd(16'h002B);
			check(d, 8'h00);
			wr(16'h002B, 8'hFF);
			rd(16'h002B);
			check(d, 8'h04);
			rd(16'h002C);
			check(d, 8'h00);
		end
	endtask
	task t_resets;
		begin
			pulse_wdg;
			rd(16'h002B);
			check(d, 8'h01);
			check({6'h00, cause}, 8'h01);
			@(posedge mclk);
			lvd_req <= 1'b1;
			repeat (50) @(posedge mclk);
			lvd_req <= 1'b0;
			wait_for(2, 1'b0, 6000);
			rd(16'h002B);
			check(d, 8'h10);
			check({6'h00, cause}, 8'h02);
			pulse_wdg;
			rd(16'h002B);
			check(d, 8'h11);
			@(posedge mclk);
			ext_low <= 1'b1;
			repeat (10) @(posedge mclk);
			ext_low <= 1'b0;
			wait_for(2, 1'b0, 6000);
			rd(16'h002B);
			check(d, 8'h11);
			wr(16'h002B, 8'h00);
			rd(16'h002B);
			check(d, 8'h00);
			check({6'h00, cause}, 8'h00);
		end
	endtask
	task t_filter;
		begin
			osc_mode <= 2'h2;
			wait_for(1, 1'b1, 300);
			check({7'h00, filt}, 8'h01);
			osc_mode <= 2'h0;
			wait_for(1, 1'b0, 3000);
			check({7'h00, filt}, 8'h00);
			wait_for(0, 1'b0, 5000);
			rd(16'h002B);
			rd(16'h002B);
			check(d, 8'h00);
		end
	endtask
	task t_loss;
		begin
			wr(16'h002B, 8'h04);
			set_modes(4'h0);
			osc_mode <= 2'h1;
			wait_for(0, 1'b1, 1000);
			rd(16'h002B);
			check(d, 8'h06);
			check({7'h00, irq_req}, 8'h01);
			wait_for(3, !sys_clk, 200);
			rd(16'h002B);
			check(d, 8'h06);
			set_modes(4'h8);
			check({7'h00, irq_req}, 8'h00);
			set_modes(4'hC);
			check({7'h00, wake_req}, 8'h01);
			set_modes(4'hA);
			check({6'h00, wake_req, bkp_en}, 8'h00);
			set_modes(4'hB);
			check({7'h00, wake_req}, 8'h01);
			set_modes(4'h0);
			osc_mode <= 2'h0;
			wait_for(0, 1'b0, 3000);
			rd(16'h002B);
			check(d, 8'h06);
			rd(16'h002B);
			check(d, 8'h04);
			wait_for(3, !sys_clk, 200);
		end
	endtask
	task t_no_supervisor;
		begin
			do_reset(1'b0);
			wr(16'h002B, 8'h04);
			osc_mode <= 2'h1;
			repeat (400) @(posedge mclk);
			rd(16'h002B);
			check(d, 8'h04);
			check({7'h00, irq_req}, 8'h00);
			osc_mode <= 2'h0;
		end
	endtask

	// Main sequence
	initial begin
		n_errors = 0;
		total_checks = 0;
		rst_n = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		sup_opt = 1'b1;
		lvd_req = 1'b0;
		wdg_pulse = 1'b0;
		modes = 4'h8;
		ext_low = 1'b0;
		osc_mode = 2'h0;
		do_reset(1'b1);
		t_regs;
		t_resets;
		t_filter;
		t_loss;
		t_no_supervisor;
		end_sim;
	end
endmodule // clock_security_reset_flags_test

// file: cssr_map.vh
// Constants for the clock security supervisor and reset-cause flags.
// Assumes inclusion by bare name from the design files of this block.
// Function
// - Main oscillator keeps running during reset phase.
// - Supervisor presence fixed by non-volatile option strap.
// - Filter suppresses spikes, stops when source recovers.
// - Main lost for three backup rising edges: use backup.
// - Main recovered: return to main automatically.
// - Safe flag set by hardware; read clears after recovery.
// - Supervisor disabled: safe flag reads zero.
// - Interrupt needs flag, enable and unmasked CPU.
// - Supervisor disabled: interrupt enable has no effect.
// - Wait mode: supervisor runs, interrupt wakes device.
// - Halt freezes status, supervisor off, reset restores.
// - Interrupt wakes Active Halt, never full Halt.
// - Low-voltage flag set by hardware, cleared writing zero.
// - Low-voltage flag not relied on when detector disabled.
// - Watchdog flag cleared by zero write or low-voltage reset.
// - Reserved bits 7:5 and 3 read zero.
// - Reset cause encoded from low-voltage and watchdog flags.
// - Reset pin low during delay, then 4096 cycles.
`ifndef CSSR_MAP_VH
`define CSSR_MAP_VH

// ********************************************************************
// Register map
// ********************************************************************
`define CSSR_ADDR_STATUS      16'h002B
`define CSSR_STATUS_RESET     8'h00

// ********************************************************************
// Status register fields
// ********************************************************************
`define CSSR_BIT_WDG          0
`define CSSR_BIT_SAFE         1
`define CSSR_BIT_IRQ_EN       2
`define CSSR_BIT_LVD          4

// ********************************************************************
// Reset cause codes
// ********************************************************************
`define CSSR_CAUSE_EXT        2'h0
`define CSSR_CAUSE_WDG        2'h1
`define CSSR_CAUSE_LVD        2'h2

// ********************************************************************
// Timing counts, in mclk cycles (50 MHz) or oscillator edges
// ********************************************************************
`define CSSR_SPIKE_MIN        8'h03
`define CSSR_PHASE_MAX        8'hFF
`define CSSR_GOOD_EDGES       4'h8
`define CSSR_LOSS_BKP_EDGES   2'h2
`define CSSR_RST_PULSE_CYC    8'h20
`define CSSR_RST_DELAY_CYC    13'h1000
`define CSSR_RST_FETCH_CYC    2'h2
`define CSSR_PIN_BLANK_CYC    13'h0004

`endif

// file: cssr_osc_model.sv
// Behavioural main and backup oscillators feeding the clock supervisor.
// Assumes the bench picks the main mode; the backup follows its enable.
`timescale 1ns/1ps

module cssr_osc_model #(
	parameter MAIN_HALF  = 200,
	parameter SPIKE_HALF = 30,
	parameter BKP_HALF   = 1000
) (
	input  wire [1:0] osc_mode,
	input  wire       backup_osc_enable,
	output reg        main_osc_in,
	output reg        backup_osc_in
);
	// Main source: 0 runs, 1 stopped low, 2 spiky harmonic
	initial main_osc_in = 1'b0;
	always begin
		if (osc_mode == 2'h2) begin
			#(SPIKE_HALF) main_osc_in = ~main_osc_in;
		end else begin
			#(MAIN_HALF) main_osc_in = (osc_mode == 2'h0) ? ~main_osc_in : 1'b0;
		end
	end

	// Backup stands still low while disabled
	initial backup_osc_in = 1'b0;
	always begin
		#(BKP_HALF) backup_osc_in = backup_osc_enable ? ~backup_osc_in : 1'b0;
	end
endmodule // cssr_osc_model

// file: cssr_sync.v
// Two-stage synchroniser for levels entering the mclk domain.
// Assumes inputs come from pins or other clocks; output is mclk-aligned.
`timescale 1ns/1ps

module cssr_sync #(
	parameter WIDTH = 1
) (
	input  wire             mclk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] din,
	output reg  [WIDTH-1:0] dout
);

	reg [WIDTH-1:0] meta;

	// First stage feeds only the second stage
	always @(posedge mclk) begin
		if (!rst_n) begin
			meta <= {WIDTH{1'b0}};
			dout <= {WIDTH{1'b0}};
		end else begin
			meta <= din;
			dout <= meta;
		end
	end

endmodule // cssr_sync

// file: cssr_top.v
// Clock security supervisor with clock filter, backup switch-over,
// reset sequencer and the clock/reset status register.
// Assumes one 50 MHz mclk, synchronous active-low rst_n, oscillators
// and the external reset pin arriving asynchronously, and CPU-side
// strobes, mode levels and reset requests on mclk.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "cssr_map.vh"

module cssr_top (
	input  wire        mclk,
	input  wire        rst_n,
	// Register port
	input  wire [15:0] reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	// Non-volatile option straps
	input  wire        supervisor_option,
	input  wire        low_voltage_detector_option,
	// Oscillator pins
	input  wire        main_osc_in,
	input  wire        backup_osc_in,
	output wire        main_osc_enable,
	output wire        backup_osc_enable,
	output reg         sys_clk_out,
	output wire        safe_clock_sel,
	output wire        filter_active,
	// Reset sources and reset pin
	input  wire        reset_pin_in,
	output wire        reset_pin_out,
	output wire        reset_pin_oe,
	input  wire        lvd_reset_req,
	input  wire        wdg_reset_pulse,
	output wire        cpu_reset,
	output wire [1:0]  reset_cause,
	// CPU state and interrupt
	input  wire        cpu_irq_mask,
	input  wire        wait_mode,
	input  wire        halt_mode,
	input  wire        active_halt_mode,
	output wire        irq_req,
	output wire        wake_req
);

	// ********************************************************************
	// Reset sequencer states
	// ********************************************************************
	localparam ST_IDLE  = 4'b0001;
	localparam ST_DELAY = 4'b0010;
	localparam ST_INT   = 4'b0100;
	localparam ST_FETCH = 4'b1000;

	// ********************************************************************
	// Declarations
	// ********************************************************************
	wire [2:0]  sync_out;
	wire        main_lvl;
	wire        bkp_lvl;
	wire        pin_low;
	reg         sup_en;
	reg         lvd_en;
	reg         main_prev;
	reg         bkp_prev;
	reg  [7:0]  phase_cnt;
	reg  [3:0]  good_cnt;
	reg         filt_on;
	reg         filt_lvl;
	reg  [1:0]  loss_cnt;
	reg         safe_sel;
	reg         out_src;
	reg  [3:0]  rst_state;
	reg  [3:0]  next_rst_state;
	reg  [12:0] rst_cnt;
	reg  [12:0] next_rst_cnt;
	reg         rst_from_ext;
	reg         next_rst_from_ext;
	reg         flag_wdg;
	reg         flag_lvd;
	reg         flag_safe;
	reg         irq_en;
	wire        sup_run;
	wire        main_edge;
	wire        bkp_rise;
	wire        spike;
	wire        valid_edge;
	wire        status_hit;
	wire        rd_status;
	wire        wr_status;
	wire        rst_enter;
	wire        safe_set;
	wire        want_src;
	wire        want_lvl;
	wire [7:0]  status_view;

	// ********************************************************************
	// Input synchronisers
	// ********************************************************************
	cssr_sync #(
		.WIDTH (3)
	) cssr_sync_i (
		.mclk  (mclk),
		.rst_n (rst_n),
		.din   ({~reset_pin_in, backup_osc_in, main_osc_in}),
		.dout  (sync_out)
	);

	assign main_lvl = sync_out[0];
	assign bkp_lvl  = sync_out[1];
	assign pin_low  = sync_out[2];

	// Options latched only while in reset, fixed at run time
	always @(posedge mclk) begin
		if (!rst_n) begin
			sup_en <= supervisor_option;
			lvd_en <= low_voltage_detector_option;
		end
	end

	// ********************************************************************
	// Mode qualification
	// ********************************************************************
	// Supervisor stops in full Halt and Active Halt, runs in Wait
	assign sup_run = sup_en & ~halt_mode;

	// Main oscillator is never stopped by reset, only by Halt
	assign main_osc_enable   = ~halt_mode | active_halt_mode;
	assign backup_osc_enable = sup_run;

	// ********************************************************************
	// Edge detection on the oscillators
	// ********************************************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			main_prev <= 1'b0;
			bkp_prev  <= 1'b0;
		end else begin
			main_prev <= main_lvl;
			bkp_prev  <= bkp_lvl;
		end
	end

	assign main_edge = main_lvl ^ main_prev;
	assign bkp_rise  = bkp_lvl & ~bkp_prev;

	// ********************************************************************
	// Clock filter
	// ********************************************************************
	// A phase shorter than the minimum is a spike
	assign spike      = main_edge & (phase_cnt < `CSSR_SPIKE_MIN);
	assign valid_edge = main_edge & ~spike;

	// Measure each main phase, saturating
	always @(posedge mclk) begin
		if (!rst_n) begin
			// Start saturated so the first edge after reset is never a spike
			phase_cnt <= `CSSR_PHASE_MAX;
		end else if (main_edge) begin
			phase_cnt <= 8'h00;
		end else if (phase_cnt != `CSSR_PHASE_MAX) begin
			phase_cnt <= phase_cnt + 8'h01;
		end
	end

	// Filter engages on a spike, releases after a run of good edges
	always @(posedge mclk) begin
		if (!rst_n || rst_enter) begin
			filt_on  <= 1'b0;
			good_cnt <= 4'h0;
		end else if (!sup_run) begin
			filt_on  <= filt_on;
			good_cnt <= good_cnt;
		end else if (spike) begin
			filt_on  <= 1'b1;
			good_cnt <= 4'h0;
		end else if (valid_edge && filt_on) begin
			if (good_cnt == `CSSR_GOOD_EDGES - 4'h1) begin
				filt_on  <= 1'b0;
				good_cnt <= 4'h0;
			end else begin
				good_cnt <= good_cnt + 4'h1;
			end
		end
	end

	// Filtered main level, held low while filtering
	always @(posedge mclk) begin
		if (!rst_n) begin
			filt_lvl <= 1'b0;
		end else if (filt_on && sup_run) begin
			filt_lvl <= 1'b0;
		end else begin
			filt_lvl <= main_prev;
		end
	end

	assign filter_active = filt_on & sup_run;

	// ********************************************************************
	// Loss detection and backup selection
	// ********************************************************************
	// Backup rising edges counted since the last good main edge
	always @(posedge mclk) begin
		if (!rst_n || rst_enter) begin
			loss_cnt <= 2'h0;
			safe_sel <= 1'b0;
		end else if (!sup_run) begin
			loss_cnt <= loss_cnt;
			safe_sel <= safe_sel;
		end else if (valid_edge && !filt_on) begin
			loss_cnt <= 2'h0;
			if (good_cnt == 4'h0 && safe_sel && phase_cnt != `CSSR_PHASE_MAX) begin
				safe_sel <= 1'b0;
			end
		end else if (bkp_rise) begin
			if (loss_cnt == `CSSR_LOSS_BKP_EDGES) begin
				safe_sel <= 1'b1;
			end else begin
				loss_cnt <= loss_cnt + 2'h1;
			end
		end
	end

	assign safe_set       = sup_run & bkp_rise & (loss_cnt == `CSSR_LOSS_BKP_EDGES);
	assign safe_clock_sel = safe_sel;

	// ********************************************************************
	// Glitch-free clock output
	// ********************************************************************
	assign want_src = safe_sel;
	assign want_lvl = want_src ? bkp_prev : filt_lvl;

	// Source changes only while the new source is low; back to main
	// also waits for the output to be low so no high pulse is cut
	always @(posedge mclk) begin
		if (!rst_n) begin
			out_src     <= 1'b0;
			sys_clk_out <= 1'b0;
		end else if (out_src != want_src) begin
			if (!want_lvl && (want_src || !sys_clk_out)) begin
				out_src     <= want_src;
				sys_clk_out <= 1'b0;
			end else begin
				// Keep following the old source so a high output can fall
				sys_clk_out <= out_src ? bkp_prev : filt_lvl;
			end
		end else begin
			sys_clk_out <= out_src ? bkp_prev : filt_lvl;
		end
	end

	// ********************************************************************
	// Reset sequencer
	// ********************************************************************
	assign rst_enter = (rst_state != ST_DELAY) & (next_rst_state == ST_DELAY);

	// Delay phase per source, then internal count, then vector fetch
	always @* begin
		next_rst_state    = rst_state;
		next_rst_cnt      = rst_cnt;
		next_rst_from_ext = rst_from_ext;
		case (rst_state)
			ST_IDLE: begin
				if (lvd_reset_req || wdg_reset_pulse || pin_low) begin
					next_rst_state    = ST_DELAY;
					next_rst_cnt      = 13'h0000;
					next_rst_from_ext = ~lvd_reset_req & ~wdg_reset_pulse;
				end
			end
			ST_DELAY: begin
				if (rst_cnt[7:0] != `CSSR_RST_PULSE_CYC) begin
					next_rst_cnt = rst_cnt + 13'h0001;
				end else if (!lvd_reset_req) begin
					next_rst_state = ST_INT;
					next_rst_cnt   = 13'h0000;
				end
			end
			ST_INT: begin
				if (lvd_reset_req) begin
					next_rst_state = ST_DELAY;
					next_rst_cnt   = 13'h0000;
				end else if (pin_low && rst_cnt >= `CSSR_PIN_BLANK_CYC) begin
					// Own pin drive echoes through the synchroniser; blank it
					next_rst_state    = ST_DELAY;
					next_rst_cnt      = 13'h0000;
					next_rst_from_ext = 1'b1;
				end else if (rst_cnt == `CSSR_RST_DELAY_CYC - 13'h0001) begin
					next_rst_state = ST_FETCH;
					next_rst_cnt   = 13'h0000;
				end else begin
					next_rst_cnt = rst_cnt + 13'h0001;
				end
			end
			ST_FETCH: begin
				if (rst_cnt[1:0] == `CSSR_RST_FETCH_CYC - 2'h1) begin
					next_rst_state = ST_IDLE;
					next_rst_cnt   = 13'h0000;
				end else begin
					next_rst_cnt = rst_cnt + 13'h0001;
				end
			end
			default: begin
				next_rst_state = ST_IDLE;
				next_rst_cnt   = 13'h0000;
			end
		endcase
	end

	// Sequencer state registers
	always @(posedge mclk) begin
		if (!rst_n) begin
			rst_state    <= ST_IDLE;
			rst_cnt      <= 13'h0000;
			rst_from_ext <= 1'b0;
		end else begin
			rst_state    <= next_rst_state;
			rst_cnt      <= next_rst_cnt;
			rst_from_ext <= next_rst_from_ext;
		end
	end

	// Open-drain pin pulled low through the whole delay phase
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe  = (rst_state == ST_DELAY);
	assign cpu_reset     = (rst_state != ST_IDLE);

	// ********************************************************************
	// Status register flags
	// ********************************************************************
	assign status_hit = (reg_addr == `CSSR_ADDR_STATUS);
	assign rd_status  = reg_rd & status_hit & ~halt_mode;
	assign wr_status  = reg_wr & status_hit & ~halt_mode;

	// Reset cause flags, hardware set wins over a software clear
	always @(posedge mclk) begin
		if (!rst_n) begin
			flag_lvd <= 1'b0;
			flag_wdg <= 1'b0;
		end else if (rst_enter && lvd_reset_req) begin
			flag_lvd <= 1'b1;
			flag_wdg <= 1'b0;
		end else if (rst_enter && wdg_reset_pulse) begin
			flag_wdg <= 1'b1;
		end else if (wr_status) begin
			if (!reg_wdata[`CSSR_BIT_LVD]) begin
				flag_lvd <= 1'b0;
			end
			if (!reg_wdata[`CSSR_BIT_WDG]) begin
				flag_wdg <= 1'b0;
			end
		end
	end

	// Safe flag: set on switch-over, cleared by read once main is back
	always @(posedge mclk) begin
		if (!rst_n || rst_enter) begin
			flag_safe <= 1'b0;
		end else if (safe_set) begin
			flag_safe <= 1'b1;
		end else if (rd_status && !safe_sel) begin
			flag_safe <= 1'b0;
		end
	end

	// Interrupt enable, software owned, reset value on any reset
	always @(posedge mclk) begin
		if (!rst_n || rst_enter) begin
			irq_en <= 1'b0;
		end else if (wr_status) begin
			irq_en <= reg_wdata[`CSSR_BIT_IRQ_EN];
		end
	end

	// ********************************************************************
	// Read path
	// ********************************************************************
	// Reserved bits tie to zero; safe flag forced low without supervisor
	assign status_view = {3'b000,
		flag_lvd,
		1'b0,
		irq_en,
		flag_safe & sup_en,
		flag_wdg};

	// Read data one cycle after the strobe, zero for other addresses
	always @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata <= `CSSR_STATUS_RESET;
		end else if (reg_rd && status_hit) begin
			reg_rdata <= status_view;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ********************************************************************
	// Reset cause and interrupt
	// ********************************************************************
	// Low-voltage flag only trusted while the detector is enabled
	assign reset_cause = (flag_lvd && lvd_en) ? `CSSR_CAUSE_LVD :
		(flag_wdg ? `CSSR_CAUSE_WDG : `CSSR_CAUSE_EXT);

	// Request needs flag, enable, unmasked CPU and the supervisor present
	assign irq_req = flag_safe & irq_en & ~cpu_irq_mask & sup_en;

	// Wakes Wait and Active Halt, never full Halt
	assign wake_req = flag_safe & irq_en & sup_en
		& (wait_mode | (halt_mode & active_halt_mode));

endmodule // cssr_top

// file: cssr_top_sva.sv
// Checker for the clock supervisor, reset sequencer and status register.
// Assumes binding to cssr_top; one mclk domain with synchronous rst_n.
`timescale 1ns/1ps

module cssr_top_chk (
	input wire       mclk,
	input wire       rst_n,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       wait_mode,
	input wire       halt_mode,
	input wire       active_halt_mode,
	input wire       cpu_irq_mask,
	input wire       irq_req,
	input wire       wake_req,
	input wire       main_osc_enable,
	input wire       backup_osc_enable,
	input wire       reset_pin_oe,
	input wire       reset_pin_out,
	input wire       cpu_reset,
	input wire       wdg_reset_pulse,
	input wire [1:0] reset_cause
);
	// ********************************
	// Properties
	// ********************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_rsvd; reg_rdata[7:5] == 3'h0 && reg_rdata[3] == 1'b0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_irq_mask; irq_req |-> !cpu_irq_mask; endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");
	property p_wake; wake_req |-> wait_mode || (halt_mode && active_halt_mode); endproperty
	a_wake: assert property (p_wake) else $error("wake outside wait or active halt");
	property p_irq_wait; irq_req && wait_mode |-> wake_req; endproperty
	a_irq_wait: assert property (p_irq_wait) else $error("interrupt did not wake wait");
	property p_bkp_halt; halt_mode |-> !backup_osc_enable; endproperty
	a_bkp_halt: assert property (p_bkp_halt) else $error("backup runs in halt");
	property p_main_run; cpu_reset && !halt_mode |-> main_osc_enable; endproperty
	a_main_run: assert property (p_main_run) else $error("main oscillator off in reset");
	property p_oe; reset_pin_oe |-> cpu_reset && !reset_pin_out; endproperty
	a_oe: assert property (p_oe) else $error("pin drive outside reset");
	property p_delay; $rose(reset_pin_oe) |-> reset_pin_oe [*8]; endproperty
	a_delay: assert property (p_delay) else $error("delay phase too short");
	property p_int; $fell(reset_pin_oe) |-> cpu_reset [*8]; endproperty
	a_int: assert property (p_int) else $error("internal reset phase missing");
	property p_wdg; wdg_reset_pulse && !cpu_reset |=> reset_pin_oe ##0 reset_cause != 2'h0;
	endproperty
	a_wdg: assert property (p_wdg) else $error("watchdog reset not taken");
	property p_cause; reset_cause != 2'h3; endproperty
	a_cause: assert property (p_cause) else $error("bad reset cause code");
endmodule // cssr_top_chk

bind cssr_top cssr_top_chk cssr_top_chk_i (.mclk, .rst_n, .reg_rd, .reg_rdata, .wait_mode,
	.halt_mode, .active_halt_mode, .cpu_irq_mask, .irq_req, .wake_req, .main_osc_enable,
	.backup_osc_enable, .reset_pin_oe, .reset_pin_out, .cpu_reset, .wdg_reset_pulse,
	.reset_cause);
